// [rtl/crg_core_state.sv]
// Core privilege, mode, banked stack and special register state
//
// Summary of operation
// - Handler mode exists only privileged; user handler never occurs.
// - Handler mode while servicing an exception, thread mode otherwise.
// - User level access to restricted registers is blocked and faults.
// - Privileged level may access every register without privilege fault.
// - All sixteen core registers are 32 bits wide.
// - Registers 0-7 reachable by all encodings; 8-12 only by wide ones.
// - Stack register banked between main and process stack pointers.
// - Stack pointer low two bits ignored, read as zero.
// - A subroutine call loads the return address register.
// - Instruction pointer bit 0 ignored, read as zero.
// - Status word of three parts; result flags in bits 27-31.
// - Exception number of current service held in bits 0-8.
// - Continuable and conditional block state in bits 10-15, 25-26.
// - Bit 24 always reads 1; clearing it raises a fault.
// - Global mask admits only nmi and hard fault.
// - Fault mask admits only nmi.
// - Threshold blocks priorities equal or above it; zero disables.
// - Mode control bit 0 selects privileged or user thread.
// - Mode control bit 1 selects main or alternate stack.
// - Stack select bit reads 0 in handler mode.
// - Only the compact mixed-width instruction set is supported.
// - Bit-band single-bit access; unaligned data supported by the core.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module crg_core_state
  import crg_pkg::*;
#(
  parameter int NGPR   = 13,
  parameter int PRIO_W = 9,
  parameter int NUM_W  = 9
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [11:0]       avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              irq_req,
  input  wire logic [NUM_W-1:0]  irq_num,
  input  wire logic [PRIO_W-1:0] irq_prio,
  output logic                   exc_taken,
  output logic                   handler_mode,
  output logic                   user_level,
  output logic                   psp_active,
  output logic                   priv_fault
);
`include "crg_regs.svh"

  // ==========================================================
  // State
  crg_mode_t         mode_q;
  logic [31:0]       gpr_q [NGPR];
  logic [31:0]       msp_q;
  logic [31:0]       psp_q;
  logic [31:0]       lr_q;
  logic [31:0]       pc_q;
  logic [4:0]        flags_q;
  logic [5:0]        ici_q;
  logic [1:0]        itl_q;
  logic [NUM_W-1:0]  exception_number_status_q;
  logic              gmask_q;
  logic              fmask_q;
  logic [PRIO_W-1:0] thr_q;
  logic [1:0]        ctrl_q;
  logic [31:0]       rdata_q;
  logic              wait_q;
  logic              taken_q;
  logic              fault_q;
  logic              hnd_q;
  logic              usr_q;
  logic              psp_q_act;

  // ==========================================================
  // Decode
  logic              acc;
  logic              wr;
  logic              is_user;
  logic              use_psp;
  logic              restr;
  logic              deny;
  logic              bad_t;
  logic              bad_nar;
  logic [31:0]       rdat;
  logic [31:0]       psw;
  logic [31:0]       sp_cur;
  logic [31:0]       wmrg;
  logic [3:0]        gidx;
  logic              gsel;
  logic              bsel;
  logic [4:0]        bbit;
  logic              take;
  logic              xret;

  crg_mask_if #(.PRIO_W(PRIO_W), .NUM_W(NUM_W)) mif ();

  crg_irq_gate u_gate (
    .m (mif.gate)
  );

  // Feed the gate with live masks and the pending request
  assign mif.gmask = gmask_q;
  assign mif.fmask = fmask_q;
  assign mif.thr   = thr_q;
  assign mif.num   = irq_num;
  assign mif.prio  = irq_prio;

  // Byte lane merge for partial writes
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Request taken on its first cycle only
  assign acc = (avs_read || avs_write) && wait_q;
  assign wr  = acc && avs_write && !deny;

  // user level only possible in thread mode
  assign is_user = (mode_q == CRG_ST_THREAD) && ctrl_q[`CRG_C_NPRIV];
  // process stack only in thread mode
  // bit 1 picks the alternate stack
  assign use_psp = (mode_q == CRG_ST_THREAD) && ctrl_q[`CRG_C_SPSEL];
  assign sp_cur  = use_psp ? psp_q : msp_q;
  assign wmrg    = be_merge(rdat, avs_writedata, avs_byteenable);

  // three parts read together as one word
  always_comb begin
    psw = '0;
    psw[`CRG_FLAG_MSB:`CRG_FLAG_LSB] = flags_q;
    psw[`CRG_ITL_MSB:`CRG_ITL_LSB]   = itl_q;
    psw[`CRG_TBIT]                   = 1'b1;
    psw[`CRG_ICI_MSB:`CRG_ICI_LSB]   = ici_q;
    psw[`CRG_NUM_MSB:0]              = exception_number_status_q;
  end

  // Region and register decode with read data
  always_comb begin
    rdat    = '0;
    restr   = 1'b0;
    bad_nar = 1'b0;
    gsel    = 1'b0;
    bsel    = avs_address[11];
    gidx    = avs_address[5:2];
    bbit    = avs_address[6:2];
    if (bsel) begin
      // bit-band alias of one register bit
      gidx = avs_address[10:7];
      gsel = (gidx < 4'(NGPR));
      rdat = gsel ? {31'h0, gpr_q[gidx][bbit]} : '0;
    end else if (avs_address[11:6] == `CRG_R_WIDE) begin
      gsel = (gidx < 4'(NGPR));
      rdat = gsel ? gpr_q[gidx] : '0;
    end else if (avs_address[11:6] == `CRG_R_NARROW) begin
      // high registers not reachable by narrow encodings
      gsel    = (gidx < `CRG_LOW_REGS);
      bad_nar = !gsel;
      rdat    = gsel ? gpr_q[gidx] : '0;
    end else begin
      case (avs_address)
        `CRG_A_MODE:  rdat = {29'h0, use_psp, is_user, mode_q == CRG_ST_HANDLER};
        `CRG_A_PSW:   rdat = psw;
        `CRG_A_FLAGS: rdat = {flags_q, 27'h0};
        `CRG_A_EXEC:  rdat = psw & ~{flags_q, 27'h0};
        `CRG_A_GMASK: begin
          rdat  = {31'h0, gmask_q};
          restr = 1'b1;
        end
        `CRG_A_FMASK: begin
          rdat  = {31'h0, fmask_q};
          restr = 1'b1;
        end
        `CRG_A_THR: begin
          rdat  = {{(32-PRIO_W){1'b0}}, thr_q};
          restr = 1'b1;
        end
        // stack select reads 0 in handler mode
        `CRG_A_CTRL: begin
          rdat  = {30'h0, ctrl_q[`CRG_C_SPSEL] && (mode_q == CRG_ST_THREAD), ctrl_q[`CRG_C_NPRIV]};
          restr = 1'b1;
        end
        `CRG_A_MSP: begin
          rdat  = msp_q;
          restr = 1'b1;
        end
        `CRG_A_PSP:   rdat = psp_q;
        `CRG_A_SP:    rdat = sp_cur;
        `CRG_A_LR:    rdat = lr_q;
        `CRG_A_PC:    rdat = pc_q;
        `CRG_A_XRET:  restr = 1'b1;
        default:      rdat = '0;
      endcase
    end
  end

  // user level blocked from restricted registers
  assign deny = is_user && restr;
  // attempt to clear compact state bit
  assign bad_t = avs_write && !bsel && (avs_address == `CRG_A_EXEC)
               && avs_byteenable[3] && !avs_writedata[`CRG_TBIT];

  assign take = irq_req && mif.admit && (mode_q == CRG_ST_THREAD);
  assign xret = wr && !bsel && (avs_address == `CRG_A_XRET) && (mode_q == CRG_ST_HANDLER);

  // ==========================================================
  // Bus slave: one wait cycle, then answer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_q  <= 1'b1;
      rdata_q <= `CRG_RST_WORD;
    end else if (clk_en) begin
      wait_q <= !acc;
      if (acc && avs_read) begin
        rdata_q <= deny ? `CRG_RST_WORD : rdat;
      end
    end
  end

  // Fault pulse on denied or illegal access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else if (clk_en) begin
      fault_q <= acc && (deny || bad_t || bad_nar);
    end
  end

  // ==========================================================
  // Mode machine and exception number
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q  <= CRG_ST_THREAD;
      exception_number_status_q  <= '0;
      taken_q <= 1'b0;
    end else if (clk_en) begin
      taken_q <= 1'b0;
      case (mode_q)
        CRG_ST_THREAD: begin
          if (take) begin
            mode_q  <= CRG_ST_HANDLER;
            exception_number_status_q  <= irq_num;
            taken_q <= 1'b1;
          end
        end
        CRG_ST_HANDLER: begin
          // return uses current mode control bits
          if (xret) begin
            mode_q <= CRG_ST_THREAD;
            exception_number_status_q <= '0;
          end
        end
        default: mode_q <= CRG_ST_THREAD;
      endcase
    end
  end

  // ==========================================================
  // Mask registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gmask_q <= 1'b0;
      fmask_q <= 1'b0;
      thr_q   <= `CRG_RST_THR;
    end else if (clk_en && wr && !bsel) begin
      if (avs_address == `CRG_A_GMASK) begin
        gmask_q <= wmrg[0];
      end
      if (avs_address == `CRG_A_FMASK) begin
        fmask_q <= wmrg[0];
      end
      if (avs_address == `CRG_A_THR) begin
        thr_q <= wmrg[PRIO_W-1:0];
      end
    end
  end

  // Mode control register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= `CRG_RST_CTRL;
    end else if (clk_en && wr && !bsel && (avs_address == `CRG_A_CTRL)) begin
      ctrl_q[`CRG_C_NPRIV] <= wmrg[`CRG_C_NPRIV];
      // stack select held while in handler mode
      if (mode_q == CRG_ST_THREAD) begin
        ctrl_q[`CRG_C_SPSEL] <= wmrg[`CRG_C_SPSEL];
      end
    end
  end

  // ==========================================================
  // Banked stack pointers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      msp_q <= `CRG_RST_WORD;
      psp_q <= `CRG_RST_WORD;
    end else if (clk_en && wr && !bsel) begin
      // low two bits forced to zero
      if ((avs_address == `CRG_A_MSP) || ((avs_address == `CRG_A_SP) && !use_psp)) begin
        msp_q <= {wmrg[31:2], `CRG_SP_ZERO};
      end
      // active view writes the banked copy in use
      if ((avs_address == `CRG_A_PSP) || ((avs_address == `CRG_A_SP) && use_psp)) begin
        psp_q <= {wmrg[31:2], `CRG_SP_ZERO};
      end
    end
  end

  // Return address and instruction pointer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lr_q <= `CRG_RST_WORD;
      pc_q <= `CRG_RST_WORD;
    end else if (clk_en && wr && !bsel) begin
      if (avs_address == `CRG_A_LR) begin
        lr_q <= wmrg;
      end
      if (avs_address == `CRG_A_PC) begin
        pc_q <= {wmrg[31:1], `CRG_PC_ZERO};
      end
      if (avs_address == `CRG_A_CALL) begin
        lr_q <= pc_q + `CRG_CALL_LEN;
        pc_q <= {avs_writedata[31:1], `CRG_PC_ZERO};
      end
    end
  end

  // Result flags and execution state fields
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= '0;
      ici_q   <= '0;
      itl_q   <= '0;
    end else if (clk_en && wr && !bsel) begin
      if ((avs_address == `CRG_A_FLAGS) || (avs_address == `CRG_A_PSW)) begin
        flags_q <= wmrg[`CRG_FLAG_MSB:`CRG_FLAG_LSB];
      end
      if ((avs_address == `CRG_A_EXEC) && !bad_t) begin
        ici_q <= wmrg[`CRG_ICI_MSB:`CRG_ICI_LSB];
        itl_q <= wmrg[`CRG_ITL_MSB:`CRG_ITL_LSB];
      end
    end
  end

  // ==========================================================
  // General registers, word and bit-band writes
  // every register a full 32-bit word
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NGPR; i++) begin
        gpr_q[i] <= `CRG_RST_WORD;
      end
    end else if (clk_en && wr && gsel) begin
      if (bsel) begin
        gpr_q[gidx][bbit] <= avs_writedata[0];
      end else begin
        gpr_q[gidx] <= wmrg;
      end
    end
  end

  // ==========================================================
  // Status outputs registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hnd_q     <= 1'b0;
      usr_q     <= 1'b0;
      psp_q_act <= 1'b0;
    end else if (clk_en) begin
      hnd_q     <= (mode_q == CRG_ST_HANDLER);
      usr_q     <= is_user;
      psp_q_act <= use_psp;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign exc_taken       = taken_q;
  assign handler_mode    = hnd_q;
  assign user_level      = usr_q;
  assign psp_active      = psp_q_act;
  assign priv_fault      = fault_q;

endmodule : crg_core_state

// [rtl/crg_irq_gate.sv]
// Decides whether a pending exception passes the three masks
`timescale 1ns/1ps
module crg_irq_gate
  import crg_pkg::*;
(
  crg_mask_if.gate m
);
`include "crg_regs.svh"

  logic is_nmi;
  logic is_hf;
  logic thr_block;

  // Classify the request and compare against the threshold
  assign is_nmi = (m.num == `CRG_NUM_NMI);
  assign is_hf  = (m.num == `CRG_NUM_HF);
  assign thr_block = (m.thr != '0) && (m.prio >= m.thr);

  // Apply masks in order of strength
  always_comb begin
    if (is_nmi) begin
      m.admit = 1'b1;
    end else if (m.fmask) begin
      m.admit = 1'b0;
    end else if (is_hf) begin
      m.admit = 1'b1;
    end else if (m.gmask) begin
      m.admit = 1'b0;
    end else begin
      m.admit = !thr_block;
    end
  end

endmodule : crg_irq_gate

// [shared/crg_mask_if.sv]
// Mask state and pending request passed to the admission gate
`timescale 1ns/1ps
interface crg_mask_if #(
  parameter int PRIO_W = 9,
  parameter int NUM_W  = 9
);
  logic              gmask;
  logic              fmask;
  logic [PRIO_W-1:0] thr;
  logic [NUM_W-1:0]  num;
  logic [PRIO_W-1:0] prio;
  logic              admit;

  modport core (output gmask, output fmask, output thr, output num, output prio, input admit);
  modport gate (input gmask, input fmask, input thr, input num, input prio, output admit);
endinterface : crg_mask_if

// [shared/crg_pkg.sv]
// Types shared by the core state block
package crg_pkg;

  // ==========================================================
  // Execution mode, Gray coded
  typedef enum logic [1:0] {
    CRG_ST_THREAD  = 2'b00,
    CRG_ST_HANDLER = 2'b01
  } crg_mode_t;

  typedef logic [31:0] crg_word_t;

endpackage : crg_pkg

// [shared/crg_regs.svh]
// Register offsets, field positions and reset values of the core state block
`ifndef CRG_REGS_SVH
`define CRG_REGS_SVH

// ==========================================================
// Byte offsets on the register bus
`define CRG_A_MODE   12'h000
`define CRG_A_PSW    12'h004
`define CRG_A_FLAGS  12'h008
`define CRG_A_EXEC   12'h00c
`define CRG_A_GMASK  12'h010
`define CRG_A_FMASK  12'h014
`define CRG_A_THR    12'h018
`define CRG_A_CTRL   12'h01c
`define CRG_A_MSP    12'h020
`define CRG_A_PSP    12'h024
`define CRG_A_SP     12'h028
`define CRG_A_LR     12'h02c
`define CRG_A_PC     12'h030
`define CRG_A_CALL   12'h034
`define CRG_A_XRET   12'h038
// Region selects taken from address bits [11:6]
`define CRG_R_WIDE   6'h02
`define CRG_R_NARROW 6'h03
// Number of low registers reachable by narrow encodings
`define CRG_LOW_REGS 4'h8

// ==========================================================
// Program status word fields
`define CRG_FLAG_LSB 27
`define CRG_FLAG_MSB 31
`define CRG_ICI_LSB  10
`define CRG_ICI_MSB  15
`define CRG_ITL_LSB  25
`define CRG_ITL_MSB  26
`define CRG_TBIT     24
`define CRG_NUM_MSB  8

// ==========================================================
// Mode control bits and alignment
`define CRG_C_NPRIV  0
`define CRG_C_SPSEL  1
`define CRG_SP_ZERO  2'h0
`define CRG_PC_ZERO  1'h0
`define CRG_CALL_LEN 32'h0000_0004

// ==========================================================
// Exception numbers that bypass the global mask and threshold
`define CRG_NUM_NMI  9'h002
`define CRG_NUM_HF   9'h003

// ==========================================================
// Reset values
`define CRG_RST_WORD 32'h0000_0000
`define CRG_RST_THR  9'h000
`define CRG_RST_CTRL 2'h0

`endif

// [verif/crg_core_state_bench.sv]
// Self-checking bench for the core state block
`timescale 1ns/1ps
`include "crg_regs.svh"
`define CRG_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: %h versus %h", $time, (a), (b)); end end
module crg_core_state_bench;
  import crg_pkg::*;
  logic        core_clk, reset, clk_en, avs_read, avs_write, irq_req;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [8:0]  irq_num, irq_prio;
  logic        avs_waitrequest, exc_taken, handler_mode, user_level, psp_active, priv_fault;
  int          mismatches, tests_run, faults, f;

  crg_core_state DUT (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_req(irq_req), .irq_num(irq_num), .irq_prio(irq_prio), .exc_taken(exc_taken),
    .handler_mode(handler_mode), .user_level(user_level), .psp_active(psp_active), .priv_fault(priv_fault)
  );

  // Clock and fault pulse counter
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (priv_fault === 1'b1) faults++;

  task conclude;
    $display("Counts: %0d mismatches in %0d checks", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin mismatches++; conclude(); end
    @(posedge core_clk);
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CRG_CHK(q, e)
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge core_clk);
  endtask : settle
  task automatic fchk(input int n);
    repeat (3) @(negedge core_clk);
    `CRG_CHK(faults, n)
    @(posedge core_clk);
  endtask : fchk

  // Raise a request, expect entry or not, then return from the handler
  task automatic irq(input logic [8:0] num, input logic [8:0] pr, input logic exp, input logic wctl);
    logic got;
    got = 1'b0;
    irq_num <= num;
    irq_prio <= pr;
    irq_req <= 1'b1;
    repeat (4) begin @(posedge core_clk); if (exc_taken === 1'b1) got = 1'b1; end
    irq_req <= 1'b0;
    // Let an edge pass so a following request is not raised in the same step
    @(posedge core_clk);
    `CRG_CHK(got, exp)
    if (exp) begin
      `CRG_CHK(handler_mode, 1'b1)
      `CRG_CHK(user_level, 1'b0)
      `CRG_CHK(psp_active, 1'b0)
      bus(1'b0, `CRG_A_PSW, 32'h0);
      `CRG_CHK(q[8:0], num)
      if (wctl) begin
        rd(`CRG_A_CTRL, 32'h1);
        bus(1'b1, `CRG_A_CTRL, 32'h0);
      end
      bus(1'b1, `CRG_A_XRET, 32'h0);
      settle();
      `CRG_CHK(handler_mode, 1'b0)
    end
  endtask : irq

  task automatic t_reset;
    rd(`CRG_A_CTRL, 32'h0);
    rd(`CRG_A_THR, 32'h0);
    rd(`CRG_A_EXEC, 32'h0100_0000);
    rd(`CRG_A_MODE, 32'h0);
  endtask : t_reset

  task automatic t_regs;
    bus(1'b1, `CRG_A_MSP, 32'h1234_5677);
    rd(`CRG_A_MSP, 32'h1234_5674);
    bus(1'b1, `CRG_A_PC, 32'h0000_0301);
    rd(`CRG_A_PC, 32'h0000_0300);
    bus(1'b1, `CRG_A_FLAGS, 32'hffff_ffff);
    rd(`CRG_A_FLAGS, 32'hf800_0000);
    rd(`CRG_A_PSW, 32'hf900_0000);
    bus(1'b1, `CRG_A_THR, 32'hffff_ffff);
    rd(`CRG_A_THR, 32'h0000_01ff);
    rd(12'h7fc, 32'h0);
  endtask : t_regs

  task automatic t_call;
    bus(1'b1, `CRG_A_PC, 32'h0000_0100);
    bus(1'b1, `CRG_A_CALL, 32'h0000_0200);
    rd(`CRG_A_LR, 32'h0000_0104);
    rd(`CRG_A_PC, 32'h0000_0200);
  endtask : t_call

  // Request held while the clock enable is low must stall, then complete
  task automatic t_hold;
    clk_en <= 1'b0;
    avs_address <= `CRG_A_LR;
    avs_writedata <= 32'h0000_0abc;
    avs_write <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CRG_CHK(avs_waitrequest, 1'b1)
    clk_en <= 1'b1;
    bus(1'b1, `CRG_A_LR, 32'h0000_0abc);
    rd(`CRG_A_LR, 32'h0000_0abc);
  endtask : t_hold

  task automatic t_gpr;
    bus(1'b1, 12'h0a4, 32'ha5a5_0009);
    rd(12'h0a4, 32'ha5a5_0009);
    bus(1'b1, 12'h08c, 32'h5a5a_0003);
    rd(12'h0cc, 32'h5a5a_0003);
    bus(1'b1, 12'h988, 32'h0000_0001);
    rd(12'h988, 32'h0000_0001);
    rd(12'h08c, 32'h5a5a_0007);
    f = faults;
    bus(1'b0, 12'h0e4, 32'h0);
    fchk(f + 1);
  endtask : t_gpr

  task automatic t_exec;
    f = faults;
    bus(1'b1, `CRG_A_EXEC, 32'h0);
    fchk(f + 1);
    rd(`CRG_A_EXEC, 32'h0100_0000);
    bus(1'b1, `CRG_A_EXEC, 32'h0700_fc00);
    rd(`CRG_A_EXEC, 32'h0700_fc00);
    bus(1'b1, `CRG_A_EXEC, 32'h0100_0000);
  endtask : t_exec

  task automatic t_irq;
    bus(1'b1, `CRG_A_THR, 32'h0);
    irq(9'h005, 9'h010, 1'b1, 1'b0);
    bus(1'b1, `CRG_A_GMASK, 32'h1);
    irq(9'h005, 9'h010, 1'b0, 1'b0);
    irq(`CRG_NUM_HF, 9'h010, 1'b1, 1'b0);
    irq(`CRG_NUM_NMI, 9'h010, 1'b1, 1'b0);
    bus(1'b1, `CRG_A_FMASK, 32'h1);
    irq(`CRG_NUM_HF, 9'h010, 1'b0, 1'b0);
    irq(`CRG_NUM_NMI, 9'h010, 1'b1, 1'b0);
    bus(1'b1, `CRG_A_GMASK, 32'h0);
    bus(1'b1, `CRG_A_FMASK, 32'h0);
    bus(1'b1, `CRG_A_THR, 32'h4);
    irq(9'h005, 9'h004, 1'b0, 1'b0);
    irq(9'h005, 9'h003, 1'b1, 1'b0);
    bus(1'b1, `CRG_A_THR, 32'h0);
    irq(9'h005, 9'h1ff, 1'b1, 1'b0);
  endtask : t_irq

  task automatic t_user;
    bus(1'b1, `CRG_A_CTRL, 32'h3);
    settle();
    `CRG_CHK(user_level, 1'b1)
    `CRG_CHK(psp_active, 1'b1)
    bus(1'b1, `CRG_A_PSP, 32'h0000_2003);
    rd(`CRG_A_SP, 32'h0000_2000);
    f = faults;
    rd(`CRG_A_MSP, 32'h0);
    fchk(f + 1);
    bus(1'b1, `CRG_A_GMASK, 32'h1);
    fchk(f + 2);
    irq(9'h005, 9'h010, 1'b1, 1'b0);
    settle();
    `CRG_CHK(user_level, 1'b1)
    `CRG_CHK(psp_active, 1'b1)
    irq(9'h005, 9'h010, 1'b1, 1'b1);
    settle();
    `CRG_CHK(user_level, 1'b0)
    bus(1'b1, `CRG_A_CTRL, 32'h0);
    settle();
    `CRG_CHK(psp_active, 1'b0)
    rd(`CRG_A_GMASK, 32'h0);
  endtask : t_user

  // Main sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    irq_req = 1'b0;
    irq_num = 9'h000;
    irq_prio = 9'h000;
    mismatches = 0;
    tests_run = 0;
    faults = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_call();
    t_hold();
    t_gpr();
    t_exec();
    t_irq();
    t_user();
    conclude();
  end
endmodule : crg_core_state_bench

// [verif/crg_core_state_monitor.sv]
// Port checker for the core state block
`timescale 1ns/1ps
`include "crg_regs.svh"
module crg_core_state_monitor
  import crg_pkg::*;
#(
  parameter int PRIO_W = 9,
  parameter int NUM_W  = 9
) (
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              clk_en,
  input wire logic [11:0]       avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              irq_req,
  input wire logic [NUM_W-1:0]  irq_num,
  input wire logic [PRIO_W-1:0] irq_prio,
  input wire logic              exc_taken,
  input wire logic              handler_mode,
  input wire logic              user_level,
  input wire logic              psp_active,
  input wire logic              priv_fault
);
  // ==========================================================
  // Clocking and bus sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  sequence s_rd_done(logic [11:0] a);
    $fell(avs_waitrequest) && $past(avs_read) && $past(avs_address) == a;
  endsequence
  // ==========================================================
  // Checks
  a_wait_one: assert property (s_take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  a_no_user_hnd: assert property (!(handler_mode && user_level))
    else $error("user level in handler mode");
  a_enter_hnd: assert property (exc_taken |=> handler_mode [*2])
    else $error("no handler mode after entry");
  a_exc_cause: assert property (exc_taken |-> $past(irq_req) && !$past(exc_taken))
    else $error("entry without request");
  a_hnd_msp: assert property (handler_mode && $past(handler_mode) |-> !psp_active)
    else $error("process stack in handler");
  a_fault_cause: assert property (priv_fault |-> $past(avs_read || avs_write))
    else $error("fault without access");
  a_nmi_admit: assert property ((irq_req && irq_num == `CRG_NUM_NMI && !handler_mode && !exc_taken && clk_en)
    |=> exc_taken)
    else $error("nmi not taken");
  a_exec_bit: assert property (s_rd_done(`CRG_A_EXEC) |-> avs_readdata[`CRG_TBIT])
    else $error("exec bit 24 reads 0");
  a_sp_align: assert property (s_rd_done(`CRG_A_MSP) |-> avs_readdata[1:0] == `CRG_SP_ZERO)
    else $error("stack pointer unaligned");
  a_pc_align: assert property (s_rd_done(`CRG_A_PC) |-> avs_readdata[0] == `CRG_PC_ZERO)
    else $error("instr pointer bit 0 set");
  a_flag_only: assert property (s_rd_done(`CRG_A_FLAGS) |-> avs_readdata[26:0] == 27'h0)
    else $error("flags register low bits set");
endmodule : crg_core_state_monitor

bind crg_core_state crg_core_state_monitor #(.PRIO_W(PRIO_W), .NUM_W(NUM_W)) u_mon (
  .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_req(irq_req), .irq_num(irq_num), .irq_prio(irq_prio), .exc_taken(exc_taken),
  .handler_mode(handler_mode), .user_level(user_level), .psp_active(psp_active), .priv_fault(priv_fault)
);
